// >>> common/bbmc_pkg.sv
// package: register map, field positions, reset values and timing of the supply mode control
// What this block does
// - switched supply enabled in Normal, Stop, Restart; disabled in Sleep, Fail-Safe.
// - buck uses PWM in Normal, Restart; in Stop only after a transition or, under pin control, with wake high.
// - buck PWM may command 100% duty when input supply is low.
// - entering Stop switches the buck to PFM automatically, except under pin control with wake high.
// - soft start runs at power-up, Sleep to Restart, Fail-Safe to Restart.
// - soft start: minimum duty, hold steps, raise by increment until target reached.
// - status reports buck switch pin open/short and output outside 12% band.
// - status flags are informative only, never change mode or configuration.
// - status reports boost pin open/short including lost ground.
// - boost enable bit honoured only in Normal and Stop modes.
// - boost select decode: low=1 level one; low=0 level two; high bit ignored.
// - enabled boost turns on below threshold, off above threshold plus hysteresis.
// - boost-active flag set on switch-on; clear succeeds only above threshold.
// - boost always runs fixed-frequency PWM in Normal and Stop.
// - boost peak overcurrent reduces commanded duty cycle.
// - Stop auto mode: overload switches buck to PWM, raises interrupt, sets flag.
// - pin-controlled modulation in Stop: wake low PFM, high PWM, unfiltered.
// - clearing automatic-transition enable disables the auto PFM to PWM switch.
package bbmc_pkg;
  typedef enum logic [2:0] {
    BBMC_MODE_INIT,
    BBMC_MODE_NORMAL,
    BBMC_MODE_STOP,
    BBMC_MODE_RESTART,
    BBMC_MODE_SLEEP,
    BBMC_MODE_FAILSAFE
  } bbmc_mode_t;

  // register byte addresses
  localparam logic [7:0] BBMC_HARDWARE_CONTROL_REG_ADDR   = 8'h00;
  localparam logic [7:0] BBMC_STATUS_ADDR    = 8'h04;
  localparam logic [7:0] BBMC_WAKE_ADDR      = 8'h08;
  localparam logic [7:0] BBMC_STATE_ADDR     = 8'h0C;
  // hardware control fields
  localparam int BBMC_HC_BOOST_EN   = 0;
  localparam int BBMC_HC_LVL_LOW    = 1;
  localparam int BBMC_HC_LVL_HIGH   = 2;
  localparam int BBMC_HC_AUTO_EN    = 3;
  localparam int BBMC_HC_PIN_MOD    = 4;
  localparam logic [4:0] BBMC_HC_RESET = 5'h08;
  // supply status fields
  localparam int BBMC_ST_BCK_OPEN   = 0;
  localparam int BBMC_ST_BCK_SHORT  = 1;
  localparam int BBMC_ST_BCK_BAND   = 2;
  localparam int BBMC_ST_BST_OPEN   = 3;
  localparam int BBMC_ST_BST_SHORT  = 4;
  localparam int BBMC_ST_BST_GND    = 5;
  localparam int BBMC_ST_STEP_UP_ACTIVE_FLAG    = 6;
  localparam int BBMC_ST_W          = 7;
  // wake status fields
  localparam int BBMC_WK_MOD_SW     = 0;
  // soft start and boost overcurrent cut
  localparam logic [7:0] BBMC_SS_MIN_DUTY = 8'h10;
  localparam logic [7:0] BBMC_SS_STEP     = 8'h08;
  localparam logic [7:0] BBMC_SS_HOLD     = 8'h04;
  localparam logic [7:0] BBMC_DUTY_FULL   = 8'hFF;
  localparam logic [7:0] BBMC_OC_CUT      = 8'h20;
  localparam logic [7:0] BBMC_PERIOD_CYC  = 8'h32;
endpackage

// >>> common/bbmc_cmp_if.sv
// interface: synchronised comparator levels passed between the core and the boost controller
`timescale 1ns/10ps
interface bbmc_cmp_if;
  logic below_th;
  logic above_hys;
  logic level_one;
  logic boost_on;
  modport ctrl (input below_th, input above_hys, input level_one, output boost_on);
  modport core (output below_th, output above_hys, output level_one, input boost_on);
endinterface

// >>> logic/bbmc_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module bbmc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, o_q, o_d;

  always_comb begin
    o_d = o_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        o_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_q  <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_q  <= o_d;
    end
  end

  assign sync_o = o_q;
endmodule

// >>> logic/bbmc_boost_ctrl.sv
// boost on/off decision with hysteresis from synchronised comparators
`timescale 1ns/10ps
module bbmc_boost_ctrl (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // gate from mode and enable
  input  wire logic allowed_i,
  // comparators
  bbmc_cmp_if.ctrl  cmp
);
  logic on_q, on_d;

  always_comb begin
    on_d = on_q;
    if (!allowed_i) begin
      on_d = 1'b0;
    end else if (!on_q && cmp.below_th) begin
      on_d = 1'b1;
    end else if (on_q && cmp.above_hys) begin
      on_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      on_q <= 1'b0;
    end else begin
      on_q <= on_d;
    end
  end

  assign cmp.boost_on = on_q;
endmodule

// >>> logic/bbmc_top.sv
// supply mode control: gating, buck modulation and soft start, boost control, APB registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module bbmc_top
  import bbmc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // operating mode and stop command pulse
  input  wire logic [2:0]  op_mode_i,
  input  wire logic        stop_cmd_i,
  // analog comparators and detectors (asynchronous)
  input  wire logic        wake_input_pin_i,
  input  wire logic        load_over_i,
  input  wire logic        vin_low_i,
  input  wire logic        buck_at_target_i,
  input  wire logic        below_th1_i,
  input  wire logic        above_hys1_i,
  input  wire logic        below_th2_i,
  input  wire logic        above_hys2_i,
  input  wire logic        boost_peak_oc_i,
  input  wire logic [5:0]  fault_i,
  // power stage controls
  output logic             supply_en_o,
  output logic             buck_pwm_o,
  output logic [7:0]       buck_duty_o,
  output logic             buck_full_duty_o,
  output logic             buck_ss_active_o,
  output logic             boost_run_o,
  output logic             boost_pwm_o,
  output logic [7:0]       boost_duty_trim_o,
  output logic             mod_switch_irq_o
);
  // synchronise every asynchronous level
  localparam int NS = 15;
  logic [NS-1:0] raw, syn;
  assign raw = {fault_i, boost_peak_oc_i, above_hys2_i, below_th2_i, above_hys1_i, below_th1_i,
                buck_at_target_i, vin_low_i, load_over_i, wake_input_pin_i};
  bbmc_sync3 #(.W(NS)) bbmc_sync3_inst (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (raw),
    .sync_o  (syn)
  );
  logic s_wake, s_load, s_vlow, s_tgt, s_b1, s_h1, s_b2, s_h2, s_oc;
  logic [5:0] s_fault;
  assign {s_fault, s_oc, s_h2, s_b2, s_h1, s_b1, s_tgt, s_vlow, s_load, s_wake} = syn;

  // codes 6 and 7 match no state and fall into the default branches, so the supply stays off
  bbmc_mode_t mode;
  assign mode = bbmc_mode_t'(op_mode_i);

  function automatic logic mode_active(input bbmc_mode_t m);
    mode_active = (m == BBMC_MODE_NORMAL) || (m == BBMC_MODE_STOP) || (m == BBMC_MODE_RESTART);
  endfunction

  // registers
  logic [4:0]  hw_q, hw_d;
  logic [5:0]  flt_q, flt_d;
  logic        act_q, act_d;
  logic        wk_q, wk_d;
  logic        mod_sw_q, mod_sw_d;
  logic        irq_q, irq_d;
  bbmc_mode_t  prev_q, prev_d;
  logic        ss_q, ss_d;
  logic [7:0]  duty_q, duty_d;
  logic [7:0]  hold_q, hold_d;
  logic [7:0]  per_q, per_d;
  logic        ss_pend_q, ss_pend_d;
  logic [7:0]  trim_q, trim_d;
  logic [31:0] rd_q, rd_d;

  // boost comparators, level select
  bbmc_cmp_if cmp ();
  logic lvl_one;
  assign lvl_one       = hw_q[BBMC_HC_LVL_LOW];
  assign cmp.level_one = lvl_one;
  assign cmp.below_th  = lvl_one ? s_b1 : s_b2;
  assign cmp.above_hys = lvl_one ? s_h1 : s_h2;
  logic boost_allowed;
  assign boost_allowed = hw_q[BBMC_HC_BOOST_EN] &&
                         (mode == BBMC_MODE_NORMAL || mode == BBMC_MODE_STOP);
  bbmc_boost_ctrl bbmc_boost_ctrl_inst (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .allowed_i (boost_allowed),
    .cmp       (cmp)
  );
  logic boost_on_prev_q, boost_on_prev_d;

  // bus decode
  logic wr_en, rd_en;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  logic clr_act;
  assign clr_act = wr_en && (paddr_i == BBMC_STATUS_ADDR) && pwdata_i[BBMC_ST_STEP_UP_ACTIVE_FLAG];

  // control and flags
  always_comb begin
    hw_d  = hw_q;
    flt_d = flt_q | s_fault;
    act_d = act_q;
    wk_d  = wk_q;
    irq_d = 1'b0;
    boost_on_prev_d = cmp.boost_on;
    if (wr_en && paddr_i == BBMC_HARDWARE_CONTROL_REG_ADDR) begin
      hw_d = pwdata_i[4:0];
    end
    // status writes clear flags only; no mode or setting follows from them
    if (wr_en && paddr_i == BBMC_STATUS_ADDR) begin
      flt_d = (flt_q & ~pwdata_i[5:0]) | s_fault;
    end
    if (clr_act && !cmp.below_th) begin
      act_d = 1'b0;
    end
    if (cmp.boost_on && !boost_on_prev_q) begin
      act_d = 1'b1;
    end
    if (wr_en && paddr_i == BBMC_WAKE_ADDR && pwdata_i[BBMC_WK_MOD_SW]) begin
      wk_d = 1'b0;
    end
    if (mod_sw_d && !mod_sw_q && hw_q[BBMC_HC_AUTO_EN] && !hw_q[BBMC_HC_PIN_MOD]) begin
      wk_d  = 1'b1;
      irq_d = 1'b1;
    end
  end

  // buck modulation: auto switch latches until a new stop command or a change out of Stop
  always_comb begin
    mod_sw_d = mod_sw_q;
    if (mode != BBMC_MODE_STOP || stop_cmd_i || (prev_q != BBMC_MODE_STOP)) begin
      mod_sw_d = 1'b0;
    end else if (hw_q[BBMC_HC_AUTO_EN] && !hw_q[BBMC_HC_PIN_MOD] && s_load) begin
      mod_sw_d = 1'b1;
    end
  end

  logic buck_pwm;
  always_comb begin
    case (mode)
      BBMC_MODE_NORMAL, BBMC_MODE_RESTART: buck_pwm = 1'b1;
      BBMC_MODE_STOP: begin
        // wake pin drives the choice directly, without a filter
        if (hw_q[BBMC_HC_PIN_MOD]) begin
          buck_pwm = s_wake;
        end else begin
          buck_pwm = mod_sw_q;
        end
      end
      default: buck_pwm = 1'b0;
    endcase
  end

  // soft start trigger and ramp
  always_comb begin
    prev_d    = mode;
    ss_pend_d = ss_pend_q;
    ss_d      = ss_q;
    duty_d    = duty_q;
    hold_d    = hold_q;
    per_d     = per_q;
    if (mode == BBMC_MODE_RESTART &&
        (prev_q == BBMC_MODE_SLEEP || prev_q == BBMC_MODE_FAILSAFE)) begin
      ss_pend_d = 1'b1;
    end
    if (!mode_active(mode)) begin
      ss_d = 1'b0;
    end else if (ss_pend_q) begin
      ss_pend_d = 1'b0;
      ss_d      = 1'b1;
      duty_d    = BBMC_SS_MIN_DUTY;
      hold_d    = 8'h00;
      per_d     = 8'h00;
    end else if (ss_q) begin
      if (s_tgt) begin
        ss_d = 1'b0;
      end else if (per_q == BBMC_PERIOD_CYC - 8'h01) begin
        per_d = 8'h00;
        if (hold_q == BBMC_SS_HOLD - 8'h01) begin
          hold_d = 8'h00;
          duty_d = (duty_q > BBMC_DUTY_FULL - BBMC_SS_STEP) ? BBMC_DUTY_FULL
                   : duty_q + BBMC_SS_STEP;
        end else begin
          hold_d = hold_q + 8'h01;
        end
      end else begin
        per_d = per_q + 8'h01;
      end
    end
  end

  // boost overcurrent trim
  always_comb begin
    trim_d = s_oc ? BBMC_OC_CUT : 8'h00;
  end

  // read data captured in the setup phase
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      // bits above each register's fields read as zero
      rd_d = 32'h0000_0000;
      case (paddr_i)
        BBMC_HARDWARE_CONTROL_REG_ADDR: rd_d[4:0] = hw_q;
        BBMC_STATUS_ADDR:  rd_d[BBMC_ST_W-1:0] = {act_q, flt_q};
        BBMC_WAKE_ADDR:    rd_d[BBMC_WK_MOD_SW] = wk_q;
        BBMC_STATE_ADDR:   rd_d[5:0] = {cmp.boost_on, ss_q, buck_pwm, op_mode_i};
        default:           rd_d = 32'h0000_0000;
      endcase
    end
  end

  // control and flag registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_q            <= BBMC_HC_RESET;
      flt_q           <= 6'h00;
      act_q           <= 1'b0;
      wk_q            <= 1'b0;
      irq_q           <= 1'b0;
      boost_on_prev_q <= 1'b0;
    end else begin
      hw_q            <= hw_d;
      flt_q           <= flt_d;
      act_q           <= act_d;
      wk_q            <= wk_d;
      irq_q           <= irq_d;
      boost_on_prev_q <= boost_on_prev_d;
    end
  end

  // automatic modulation latch
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mod_sw_q <= 1'b0;
    end else begin
      mod_sw_q <= mod_sw_d;
    end
  end

  // soft start state; pending at reset so power-up ramps on the first active mode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q    <= BBMC_MODE_INIT;
      ss_pend_q <= 1'b1;
      ss_q      <= 1'b0;
      duty_q    <= BBMC_SS_MIN_DUTY;
      hold_q    <= 8'h00;
      per_q     <= 8'h00;
    end else begin
      prev_q    <= prev_d;
      ss_pend_q <= ss_pend_d;
      ss_q      <= ss_d;
      duty_q    <= duty_d;
      hold_q    <= hold_d;
      per_q     <= per_d;
    end
  end

  // duty trim lags the shunt comparator by the synchroniser delay plus one register cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_q <= 8'h00;
    end else begin
      trim_q <= trim_d;
    end
  end

  // read data register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 32'h0000_0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  // outputs
  assign supply_en_o       = mode_active(mode);
  assign buck_pwm_o        = supply_en_o && buck_pwm;
  assign buck_duty_o       = duty_q;
  // low input voltage lets the loop hold the high side on continuously
  assign buck_full_duty_o  = supply_en_o && buck_pwm && !ss_q && s_vlow;
  assign buck_ss_active_o  = ss_q;
  assign boost_run_o       = cmp.boost_on;
  assign boost_pwm_o       = cmp.boost_on;
  assign boost_duty_trim_o = trim_q;
  assign mod_switch_irq_o  = irq_q;
  assign prdata_o          = rd_q;
  // zero wait states: every access completes in its first access cycle
  assign pready_o          = 1'b1;
  assign pslverr_o         = 1'b0;
endmodule

// >>> sim/bbmc_checker.sv
// port-level assertions for the supply mode control, bound to the top module
`timescale 1ns/10ps
module bbmc_checker
  import bbmc_pkg::*;
(
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // mode and sensed levels
  input wire logic [2:0] op_mode_i,
  input wire logic       vin_low_i,
  input wire logic       boost_peak_oc_i,
  // power stage controls
  input wire logic       supply_en_o,
  input wire logic       buck_pwm_o,
  input wire logic [7:0] buck_duty_o,
  input wire logic       buck_full_duty_o,
  input wire logic       buck_ss_active_o,
  input wire logic       boost_run_o,
  input wire logic       boost_pwm_o,
  input wire logic [7:0] boost_duty_trim_o,
  input wire logic       mod_switch_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_SUPPLY_GATE: assert property (
    supply_en_o == (op_mode_i inside {BBMC_MODE_NORMAL, BBMC_MODE_STOP, BBMC_MODE_RESTART}))
    else $error("supply enable does not follow mode");
  AST_BUCK_PWM_MODES: assert property (
    op_mode_i inside {BBMC_MODE_NORMAL, BBMC_MODE_RESTART} |-> buck_pwm_o)
    else $error("buck not in pwm in normal or restart");
  AST_BOOST_MODE_GATE: assert property (
    boost_run_o |-> $past(op_mode_i) inside {BBMC_MODE_NORMAL, BBMC_MODE_STOP})
    else $error("boost running outside normal and stop");
  AST_BOOST_PWM: assert property (boost_run_o |-> boost_pwm_o)
    else $error("boost running without pwm");
  AST_IRQ_PULSE: assert property (mod_switch_irq_o |=> !mod_switch_irq_o)
    else $error("modulation interrupt longer than one cycle");
  AST_IRQ_IN_STOP: assert property (mod_switch_irq_o |-> $past(op_mode_i) == BBMC_MODE_STOP)
    else $error("modulation interrupt outside stop");
  AST_SS_STEP: assert property (
    $past(buck_ss_active_o) && buck_ss_active_o && $changed(buck_duty_o)
    |-> buck_duty_o == $past(buck_duty_o) + BBMC_SS_STEP)
    else $error("soft start step size wrong");
  AST_OC_TRIM: assert property (
    (boost_peak_oc_i && boost_run_o) [*6] |-> boost_duty_trim_o == BBMC_OC_CUT)
    else $error("overcurrent did not cut boost duty");
  AST_FULL_DUTY: assert property (
    (vin_low_i && buck_pwm_o && !buck_ss_active_o) [*6] |-> buck_full_duty_o)
    else $error("low input did not give full duty");
endmodule

bind bbmc_top bbmc_checker bbmc_checker_inst (.mclk_i, .rst_i, .op_mode_i, .vin_low_i, .boost_peak_oc_i,
  .supply_en_o, .buck_pwm_o, .buck_duty_o, .buck_full_duty_o, .buck_ss_active_o, .boost_run_o,
  .boost_pwm_o, .boost_duty_trim_o, .mod_switch_irq_o);

// >>> sim/bbmc_stage_model.sv
// power stage model: supply comparators, buck target detect, boost shunt
`timescale 1ns/10ps
module bbmc_stage_model #(
  parameter int TH1    = 100,
  parameter int HYS1   = 20,
  parameter int TH2    = 150,
  parameter int HYS2   = 30,
  parameter int TARGET = 32
) (
  // sensed supply code and load
  input  wire logic [7:0] vs_i,
  input  wire logic       heavy_i,
  // commands from the block
  input  wire logic [7:0] buck_duty_i,
  input  wire logic       boost_run_i,
  // detector outputs
  output logic            below_th1_o,
  output logic            above_hys1_o,
  output logic            below_th2_o,
  output logic            above_hys2_o,
  output logic            at_target_o,
  output logic            peak_oc_o
);
  assign below_th1_o  = vs_i < TH1;
  assign above_hys1_o = vs_i > TH1 + HYS1;
  assign below_th2_o  = vs_i < TH2;
  assign above_hys2_o = vs_i > TH2 + HYS2;
  // output only reaches target once the ramp has climbed far enough
  assign at_target_o  = buck_duty_i >= TARGET;
  assign peak_oc_o    = boost_run_i && heavy_i;
endmodule

// >>> sim/bbmc_top_test.sv
// self-checking bench for the supply mode control
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module bbmc_top_test;
  import bbmc_pkg::*;
  logic        mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, stop_cmd_i = 0;
  logic        wake_input_pin_i = 0, load_over_i = 0, vin_low_i = 0, heavy = 0, pready_o, pslverr_o;
  logic        below_th1_i, above_hys1_i, below_th2_i, above_hys2_i, buck_at_target_i, boost_peak_oc_i;
  logic        supply_en_o, buck_pwm_o, buck_full_duty_o, buck_ss_active_o, boost_run_o, boost_pwm_o;
  logic        mod_switch_irq_o;
  logic [7:0]  paddr_i = 0, vs = 8'hC8, buck_duty_o, boost_duty_trim_o;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [2:0]  op_mode_i = BBMC_MODE_INIT;
  logic [5:0]  fault_i = 0;
  logic [3:0]  sel[4] = '{4'h3, 4'h7, 4'h1, 4'h5};
  int          compares = 0, num_errors = 0, cycles = 0;

  bbmc_top bbmc_top_inst (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .op_mode_i, .stop_cmd_i, .wake_input_pin_i, .load_over_i, .vin_low_i,
    .buck_at_target_i, .below_th1_i, .above_hys1_i, .below_th2_i, .above_hys2_i, .boost_peak_oc_i,
    .fault_i, .supply_en_o, .buck_pwm_o, .buck_duty_o, .buck_full_duty_o, .buck_ss_active_o,
    .boost_run_o, .boost_pwm_o, .boost_duty_trim_o, .mod_switch_irq_o);
  bbmc_stage_model bbmc_stage_model_inst (.vs_i(vs), .heavy_i(heavy), .buck_duty_i(buck_duty_o),
    .boost_run_i(boost_run_o), .below_th1_o(below_th1_i), .above_hys1_o(above_hys1_i),
    .below_th2_o(below_th2_i), .above_hys2_o(above_hys2_i), .at_target_o(buck_at_target_i),
    .peak_oc_o(boost_peak_oc_i));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // one apb transfer; a cycle of idle after it so the next call never reassigns psel in the same step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i) penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    cyc(3);
    rst_i <= 1'b0;
    cyc(1);
    xfer(0, BBMC_HARDWARE_CONTROL_REG_ADDR, 0);
    `CHK("hardware_control_reg reset", 32'h0000_0008, rd)
    xfer(0, 8'h40, 0);
    `CHK("unmapped read", 32'h0000_0000, rd)
    `CHK("no slave error", 1'b0, pslverr_o)
    op_mode_i <= BBMC_MODE_RESTART;
    cyc(3);
    `CHK("ss start", 1'b1, buck_ss_active_o)
    `CHK("ss min duty", BBMC_SS_MIN_DUTY, buck_duty_o)
    cyc(300);
    `CHK("ss second step", 8'h18, buck_duty_o)
    cyc(150);
    `CHK("ss done", 1'b0, buck_ss_active_o)
    for (int m = 0; m < 6; m++) begin
      op_mode_i <= m[2:0];
      cyc(3);
      `CHK("supply en", (m inside {1, 2, 3}), supply_en_o)
      if (m == 2) `CHK("stop pfm", 1'b0, buck_pwm_o)
    end
    op_mode_i <= BBMC_MODE_RESTART;
    cyc(3);
    `CHK("ss after failsafe", 1'b1, buck_ss_active_o)
    cyc(450);
    op_mode_i <= BBMC_MODE_NORMAL;
    vin_low_i <= 1'b1;
    cyc(8);
    `CHK("full duty", 1'b1, buck_full_duty_o)
    vin_low_i <= 1'b0;
    op_mode_i <= BBMC_MODE_STOP;
    cyc(3);
    load_over_i <= 1'b1;
    for (int i = 0; i < 12 && mod_switch_irq_o !== 1'b1; i++) @(posedge mclk_i);
    `CHK("auto irq", 1'b1, mod_switch_irq_o)
    cyc(1);
    `CHK("auto pwm", 1'b1, buck_pwm_o)
    load_over_i <= 1'b0;
    xfer(0, BBMC_WAKE_ADDR, 0);
    `CHK("wake flag", 32'h0000_0001, rd)
    xfer(1, BBMC_WAKE_ADDR, 1);
    xfer(0, BBMC_WAKE_ADDR, 0);
    `CHK("wake clear", 32'h0000_0000, rd)
    `CHK("pwm held", 1'b1, buck_pwm_o)
    stop_cmd_i <= 1'b1;
    cyc(1);
    stop_cmd_i <= 1'b0;
    cyc(6);
    `CHK("stop cmd pfm", 1'b0, buck_pwm_o)
    xfer(1, BBMC_HARDWARE_CONTROL_REG_ADDR, 0);
    load_over_i <= 1'b1;
    cyc(8);
    `CHK("auto off", 1'b0, buck_pwm_o)
    load_over_i <= 1'b0;
    xfer(1, BBMC_HARDWARE_CONTROL_REG_ADDR, 32'h0000_0010);
    wake_input_pin_i <= 1'b1;
    cyc(6);
    `CHK("pin high pwm", 1'b1, buck_pwm_o)
    wake_input_pin_i <= 1'b0;
    cyc(6);
    `CHK("pin low pfm", 1'b0, buck_pwm_o)
    op_mode_i <= BBMC_MODE_NORMAL;
    // 0x82 lies between the two thresholds, so only the second one turns the boost on
    foreach (sel[k]) begin
      vs <= 8'hC8;
      xfer(1, BBMC_HARDWARE_CONTROL_REG_ADDR, {28'h0, sel[k]});
      cyc(8);
      vs <= 8'h82;
      cyc(8);
      `CHK("level decode", ~sel[k][1], boost_run_o)
    end
    vs <= 8'h5A;
    xfer(1, BBMC_HARDWARE_CONTROL_REG_ADDR, 32'h0000_0003);
    op_mode_i <= BBMC_MODE_STOP;
    heavy <= 1'b1;
    cyc(8);
    `CHK("boost on", 1'b1, boost_run_o)
    `CHK("oc trim", BBMC_OC_CUT, boost_duty_trim_o)
    `CHK("boost pwm", 1'b1, boost_pwm_o)
    heavy <= 1'b0;
    xfer(1, BBMC_STATUS_ADDR, 32'h0000_0040);
    xfer(0, BBMC_STATUS_ADDR, 0);
    `CHK("act kept", 1'b1, rd[BBMC_ST_STEP_UP_ACTIVE_FLAG])
    vs <= 8'h6E;
    cyc(8);
    `CHK("hysteresis", 1'b1, boost_run_o)
    xfer(1, BBMC_STATUS_ADDR, 32'h0000_0040);
    xfer(0, BBMC_STATUS_ADDR, 0);
    `CHK("act cleared", 1'b0, rd[BBMC_ST_STEP_UP_ACTIVE_FLAG])
    vs <= 8'h5A;
    op_mode_i <= BBMC_MODE_SLEEP;
    cyc(8);
    `CHK("boost sleep", 1'b0, boost_run_o)
    op_mode_i <= BBMC_MODE_NORMAL;
    fault_i <= 6'h3F;
    cyc(8);
    xfer(0, BBMC_STATUS_ADDR, 0);
    `CHK("faults", 6'h3F, rd[5:0])
    xfer(0, BBMC_HARDWARE_CONTROL_REG_ADDR, 0);
    `CHK("config kept", 32'h0000_0003, rd)
    `CHK("supply kept", 1'b1, supply_en_o)
    fault_i <= 6'h00;
    cyc(6);
    xfer(1, BBMC_STATUS_ADDR, 32'h0000_003F);
    xfer(0, BBMC_STATUS_ADDR, 0);
    `CHK("faults clear", 6'h00, rd[5:0])
    tally_and_finish();
  end
endmodule
